// >>> src/relay_defs.svh
`ifndef RELAY_DEFS_SVH
`define RELAY_DEFS_SVH

// -----------------------------------------------------------
// register map
// -----------------------------------------------------------
`define RELAY_IO_OFS      4'h0
`define RELAY_CMD_LSB     0
`define RELAY_REPLY_LSB   8
`define RELAY_IO_RST      16'h0000
`define RELAY_CMD_RST     8'h00
`define RELAY_REPLY_RST   4'hf

// -----------------------------------------------------------
// timing
// -----------------------------------------------------------
`define CLK_KHZ           100000
`define ALARM_DLY_MS      4
`define ALARM_CNT_W       20

`endif

// >>> src/relay_output_manual_override.sv
// The address map and the strobed register port are this design's own decisions.
`include "relay_defs.svh"

// Functional notes
// - eight relays as four channels of two, auto/manual plus 1-0-2 switch
// - automatic channel: both relays follow host command bits
// - manual: host ignored; 0 both off, 1 first on, 2 second on
// - red indicator mirrors actual relay state, forced states included
// - manual or a forcing alarm lights yellow and drives reply low, else reply high
// - command bits clear on cold restart, external reset, power down
// - manual and alarm forcing work without host activity
// - write bits 0..7 are commands, bits 8..15 ignored
// - read bits 0..7 commands, 8..11 manual replies active low
// - even bit drives first relay, odd bit second, per channel
// - alarm acts per relay, jumper picks ignore, off or on
// - alarm input asserted when low
// - ignore setting leaves relay, indicators and reply untouched
// - force off releases relay, reply low, yellow lit
// - force on energises relay, reply low, yellow lit
// - jumpers default to ignore and are a static input
// - alarm changes take effect after 4 ms of steady input, plus the sync cycles
module relay_output_manual_override #(
  parameter int ALARM_DLY_CYC =
    (`ALARM_DLY_MS * `CLK_KHZ < 1) ? 1 : `ALARM_DLY_MS * `CLK_KHZ
) (
  input  wire logic                          sys_clk,
  input  wire logic                          srst,
  input  wire logic                          clk_en,
  input  wire relay_pkg::reg_req_t           bus_req,
  output logic [15:0]                        rd_data,
  input  wire relay_pkg::pins_t              pins,
  input  wire relay_pkg::alarm_mode_t [7:0]  alarm_mode,
  output logic [7:0]                         relay_on,
  output logic [7:0]                         red_led,
  output logic [3:0]                         yellow_led
);

  // -----------------------------------------------------------
  // constants
  // -----------------------------------------------------------
  localparam logic [`ALARM_CNT_W-1:0] DLY_LAST =
    `ALARM_CNT_W'(ALARM_DLY_CYC - 1);

  localparam relay_pkg::relay_st_t ST_RST = '{
    s1      : '{ext_rst: 1'b0, pwr_down: 1'b0, alarm_n: 8'hff,
                pos2: 4'h0, pos1: 4'h0, manual: 4'h0},
    s2      : '{ext_rst: 1'b0, pwr_down: 1'b0, alarm_n: 8'hff,
                pos2: 4'h0, pos1: 4'h0, manual: 4'h0},
    cmd     : `RELAY_CMD_RST,
    rd      : `RELAY_IO_RST,
    alm     : 8'h00,
    cnt     : '0,
    relay   : 8'h00,
    reply_n : `RELAY_REPLY_RST
  };

  relay_pkg::relay_st_t st_q;
  relay_pkg::relay_st_t st_d;

  // -----------------------------------------------------------
  // helpers
  // -----------------------------------------------------------

  // does the alarm override this relay
  function automatic logic alarm_bites(
    input logic                   act,
    input relay_pkg::alarm_mode_t mode
  );
    alarm_bites = act && (mode == relay_pkg::ALM_FORCE_OFF ||
                          mode == relay_pkg::ALM_FORCE_ON);
  endfunction : alarm_bites

  // final relay level after the alarm
  function automatic logic apply_alarm(
    input logic                   base,
    input logic                   act,
    input relay_pkg::alarm_mode_t mode
  );
    if (!act) begin
      apply_alarm = base;
    end else begin
      unique case (mode)
        relay_pkg::ALM_FORCE_OFF: apply_alarm = 1'b0;
        relay_pkg::ALM_FORCE_ON:  apply_alarm = 1'b1;
        default:                  apply_alarm = base;
      endcase
    end
  endfunction : apply_alarm

  // -----------------------------------------------------------
  // next state
  // -----------------------------------------------------------

  // bus, reset sources, alarm filter and relay logic
  always_comb begin
    logic man;
    logic base0;
    logic base1;
    int   r0;
    int   r1;
    man   = 1'b0;
    base0 = 1'b0;
    base1 = 1'b0;
    r0    = 0;
    r1    = 0;
    st_d  = st_q;
    // two-stage pin synchroniser
    st_d.s1 = pins;
    st_d.s2 = st_q.s1;
    // read data stand one cycle only
    st_d.rd = 16'h0000;
    if (bus_req.rd && bus_req.addr == `RELAY_IO_OFS) begin
      st_d.rd = {4'h0, st_q.reply_n, st_q.cmd};
    end
    if (bus_req.wr && bus_req.addr == `RELAY_IO_OFS) begin
      st_d.cmd = bus_req.wdata[7:0];
    end
    // external reset and power down win over a write
    if (st_q.s2.ext_rst || st_q.s2.pwr_down) begin
      st_d.cmd = `RELAY_CMD_RST;
    end
    // alarm delay filter, low input means asserted
    for (int i = 0; i < 8; i++) begin
      if (!st_q.s2.alarm_n[i] != st_q.alm[i]) begin
        if (st_q.cnt[i] == DLY_LAST) begin
          st_d.alm[i] = !st_q.s2.alarm_n[i];
          st_d.cnt[i] = '0;
        end else begin
          st_d.cnt[i] = `ALARM_CNT_W'(st_q.cnt[i] + 1'b1);
        end
      end else begin
        st_d.cnt[i] = '0;
      end
    end
    // per channel: selector, 1-0-2 switch, alarm
    for (int ch = 0; ch < 4; ch++) begin
      r0  = 2 * ch;
      r1  = 2 * ch + 1;
      man = st_q.s2.manual[ch];
      if (man) begin
        base0 = st_q.s2.pos1[ch] && !st_q.s2.pos2[ch];
        base1 = st_q.s2.pos2[ch] && !st_q.s2.pos1[ch];
      end else begin
        base0 = st_q.cmd[r0];
        base1 = st_q.cmd[r1];
      end
      // no interlock between the pair
      st_d.relay[r0] = apply_alarm(base0, st_q.alm[r0],
                                   alarm_mode[r0]);
      st_d.relay[r1] = apply_alarm(base1, st_q.alm[r1],
                                   alarm_mode[r1]);
      st_d.reply_n[ch] =
        !(man ||
          alarm_bites(st_q.alm[r0], alarm_mode[r0]) ||
          alarm_bites(st_q.alm[r1], alarm_mode[r1]));
    end
  end

  // -----------------------------------------------------------
  // state register
  // -----------------------------------------------------------

  // override path needs no bus traffic, only the clock with clk_en high
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_q <= ST_RST;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // -----------------------------------------------------------
  // outputs
  // -----------------------------------------------------------

  // red indicators follow the driven relay level, yellow ones the inverted reply
  assign rd_data    = st_q.rd;
  assign relay_on   = st_q.relay;
  assign red_led    = st_q.relay;
  assign yellow_led = ~st_q.reply_n;

  // -----------------------------------------------------------
  // checks
  // -----------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  // bus side: write and read images
  a_write_image: assert property (
    !srst && clk_en && bus_req.wr && bus_req.addr == `RELAY_IO_OFS &&
    !st_q.s2.ext_rst && !st_q.s2.pwr_down
    |=> st_q.cmd == $past(bus_req.wdata[7:0]))
    else $error("command bits not taken from write");

  a_read_image: assert property (
    !srst && clk_en && bus_req.rd && bus_req.addr == `RELAY_IO_OFS
    |=> rd_data == {4'h0, $past(st_q.reply_n), $past(st_q.cmd)})
    else $error("read image wrong");

  a_read_once: assert property (
    !srst && clk_en && !bus_req.rd |=> rd_data == 16'h0000)
    else $error("read data held past its cycle");

  a_cmd_cleared: assert property (
    !srst && clk_en && (st_q.s2.ext_rst || st_q.s2.pwr_down)
    |=> st_q.cmd == 8'h00)
    else $error("command bits survive reset source");

  // relay behaviour per channel
  a_auto_follow: assert property (
    !srst && clk_en && !st_q.s2.manual[0] && !st_q.alm[0] && !st_q.alm[1]
    |=> relay_on[1:0] == $past(st_q.cmd[1:0]))
    else $error("automatic channel ignores command");

  a_manual_sw: assert property (
    !srst && clk_en && st_q.s2.manual[1] && !st_q.alm[2] && !st_q.alm[3]
    |=> relay_on[3:2] ==
        {$past(st_q.s2.pos2[1]) && !$past(st_q.s2.pos1[1]),
         $past(st_q.s2.pos1[1]) && !$past(st_q.s2.pos2[1])}
        ##0 yellow_led[1])
    else $error("manual switch not obeyed");

  a_force_off: assert property (
    !srst && clk_en && st_q.alm[4] &&
    alarm_mode[4] == relay_pkg::ALM_FORCE_OFF
    |=> !relay_on[4] && !red_led[4] && yellow_led[2])
    else $error("force off alarm not applied");

  a_force_on: assert property (
    !srst && clk_en && st_q.alm[7] &&
    alarm_mode[7] == relay_pkg::ALM_FORCE_ON
    |=> relay_on[7] && red_led[7] && !st_q.reply_n[3])
    else $error("force on alarm not applied");

  a_ignore_alarm: assert property (
    !srst && clk_en && !st_q.s2.manual[3] &&
    (alarm_mode[6] == relay_pkg::ALM_IGNORE ||
     alarm_mode[6] == relay_pkg::ALM_SPARE) &&
    (alarm_mode[7] == relay_pkg::ALM_IGNORE ||
     alarm_mode[7] == relay_pkg::ALM_SPARE)
    |=> relay_on[6] == $past(st_q.cmd[6]) && st_q.reply_n[3])
    else $error("ignored alarm changed outputs");

  a_alarm_delay: assert property (
    !srst && !$past(srst) && $changed(st_q.alm[0])
    |-> $past(st_q.cnt[0]) == DLY_LAST)
    else $error("alarm took effect before its delay");

  // enable low freezes every flop
  a_freeze_hold: assert property (
    !srst && !clk_en |=> st_q == $past(st_q))
    else $error("state moved while clock enable low");

  // pins pass both sync flops in order
  a_pin_sync: assert property (
    !srst && clk_en |=> st_q.s2 == $past(st_q.s1))
    else $error("second sync stage skipped the first");

  // write to a spare address leaves commands alone
  a_unmapped_write: assert property (
    !srst && clk_en && bus_req.wr && bus_req.addr != `RELAY_IO_OFS &&
    !st_q.s2.ext_rst && !st_q.s2.pwr_down
    |=> st_q.cmd == $past(st_q.cmd))
    else $error("write to spare address changed commands");

  // manual lights yellow, automatic without alarm keeps it dark
  a_manual_reply: assert property (
    !srst && clk_en && st_q.s2.manual[2]
    |=> yellow_led[2] && !st_q.reply_n[2])
    else $error("manual channel not reported");

  a_auto_reply: assert property (
    !srst && clk_en && !st_q.s2.manual[0] &&
    !alarm_bites(st_q.alm[0], alarm_mode[0]) &&
    !alarm_bites(st_q.alm[1], alarm_mode[1])
    |=> !yellow_led[0] && st_q.reply_n[0])
    else $error("automatic channel reported as manual");

  // spare jumper code behaves as ignore
  a_spare_code: assert property (
    !srst && clk_en && !st_q.s2.manual[2] &&
    alarm_mode[5] == relay_pkg::ALM_SPARE
    |=> relay_on[5] == $past(st_q.cmd[5]))
    else $error("spare jumper code forced relay");

  // filter stays put while the input agrees
  a_alarm_hold: assert property (
    !srst && clk_en && (!st_q.s2.alarm_n[1] == st_q.alm[1])
    |=> st_q.alm[1] == $past(st_q.alm[1]) && st_q.cnt[1] == '0)
    else $error("alarm filter moved without input change");

  // filter takes the new level once the count is full
  a_alarm_take: assert property (
    !srst && clk_en && st_q.cnt[3] == DLY_LAST &&
    (!st_q.s2.alarm_n[3] != st_q.alm[3])
    |=> st_q.alm[3] == !$past(st_q.s2.alarm_n[3]))
    else $error("alarm level not taken after delay");

  // force on wins over a manual switch position
  a_force_man: assert property (
    !srst && clk_en && st_q.s2.manual[0] && st_q.alm[1] &&
    alarm_mode[1] == relay_pkg::ALM_FORCE_ON
    |=> relay_on[1] && yellow_led[0])
    else $error("force on lost against manual switch");

endmodule : relay_output_manual_override

// >>> src/relay_pkg.sv
`include "relay_defs.svh"

package relay_pkg;

  // alarm jumper choice per relay, spare code acts as ignore
  typedef enum logic [1:0] {
    ALM_IGNORE    = 2'h0,
    ALM_FORCE_OFF = 2'h1,
    ALM_FORCE_ON  = 2'h2,
    ALM_SPARE     = 2'h3
  } alarm_mode_t;

  // register bus request
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // field pins, all asynchronous to sys_clk
  typedef struct packed {
    logic       ext_rst;
    logic       pwr_down;
    logic [7:0] alarm_n;
    logic [3:0] pos2;
    logic [3:0] pos1;
    logic [3:0] manual;
  } pins_t;

  // whole state of the output block
  typedef struct packed {
    pins_t                        s1;
    pins_t                        s2;
    logic [7:0]                   cmd;
    logic [15:0]                  rd;
    logic [7:0]                   alm;
    logic [7:0][`ALARM_CNT_W-1:0] cnt;
    logic [7:0]                   relay;
    logic [3:0]                   reply_n;
  } relay_st_t;

endpackage : relay_pkg

// >>> verification/io_host.sv
// ---------------------------------------------
// host side of the register bus
// ---------------------------------------------
module io_host (
  input  wire logic           sys_clk,
  output relay_pkg::reg_req_t bus_req,
  input  wire logic [15:0]    rd_data
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle bus at time zero
  initial begin
    bus_req = '0;
  end

  // one write cycle, upper byte carries junk
  task put_word(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus_req.wr    <= 1'b0;
    bus_req.wdata <= ~d; // released data never shows stale value
  endtask : put_word

  // one read cycle, data taken in the following cycle
  task get_word(input logic [3:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: ~bus_req.wdata, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    @(posedge sys_clk);
    d = rd_data; // taken at the edge closing the data cycle
  endtask : get_word
endmodule : io_host

// >>> verification/testbench.sv
// ---------------------------------------------
// self-checking bench
// ---------------------------------------------
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                         sys_clk;
  logic                         srst;
  logic                         clk_en;
  relay_pkg::reg_req_t          bus_req;
  logic [15:0]                  rd_data;
  relay_pkg::pins_t             pins;
  relay_pkg::alarm_mode_t [7:0] alarm_mode;
  logic [7:0]                   relay_on;
  logic [7:0]                   red_led;
  logic [3:0]                   yellow_led;
  logic [15:0]                  rdw;
  int                           fails;
  int                           n_compared;
  int                           m_cmd;
  int                           rel;
  int                           rep;
  int                           wd;

  relay_output_manual_override #(
    .ALARM_DLY_CYC (4)
  ) u_relay_output_manual_override (
    .sys_clk    (sys_clk),
    .srst       (srst),
    .clk_en     (clk_en),
    .bus_req    (bus_req),
    .rd_data    (rd_data),
    .pins       (pins),
    .alarm_mode (alarm_mode),
    .relay_on   (relay_on),
    .red_led    (red_led),
    .yellow_led (yellow_led)
  );

  io_host u_io_host (
    .sys_clk (sys_clk),
    .bus_req (bus_req),
    .rd_data (rd_data)
  );

  // compare and count
  task check(string what, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask : check

  // verdict and end of run
  task test_done;
    $display("fails %0d compared %0d", fails, n_compared);
    if (fails == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  // reference model of relays and replies
  function automatic void model(output int rl, output int rp);
    int b;
    int a;
    int m;
    int c;
    rl = 0;
    rp = 15;
    for (int r = 0; r < 8; r++) begin
      c = r / 2;
      m = int'(alarm_mode[r]);
      if (pins.manual[c]) begin
        b = (r % 2 == 0) ? (pins.pos1[c] && !pins.pos2[c])
                         : (pins.pos2[c] && !pins.pos1[c]);
      end else begin
        b = (m_cmd >> r) & 1;
      end
      a = !pins.alarm_n[r] && (m == 1 || m == 2);
      if (a) begin
        b = (m == 2);
      end
      rl |= b << r;
      if (pins.manual[c] || a) begin
        rp &= ~(1 << c);
      end
    end
  endfunction : model

  // clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // watchdog
  initial begin
    #200000;
    fails++;
    test_done();
  end

  // main sequence
  initial begin
    srst = 1'b1;
    clk_en = 1'b1;
    pins = '0;
    pins.alarm_n = 8'hff;
    alarm_mode = '0;
    fails = 0;
    n_compared = 0;
    m_cmd = 0;
    void'($urandom(84));
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    // both relays of every channel on together, no interlock
    u_io_host.put_word(4'h0, 16'h00ff);
    m_cmd = 255;
    repeat (4) @(posedge sys_clk);
    check("pair", {8'h00, relay_on}, 16'h00ff);
    // short alarm pulse is filtered out
    alarm_mode[0] <= relay_pkg::ALM_FORCE_OFF;
    pins.alarm_n[0] <= 1'b0;
    repeat (2) @(posedge sys_clk);
    pins.alarm_n[0] <= 1'b1;
    for (int k = 0; k < 10; k++) begin
      @(posedge sys_clk);
      check("glitch", {8'h00, relay_on}, 16'h00ff);
    end
    // held alarm forces relay 0 off
    pins.alarm_n[0] <= 1'b0;
    repeat (12) @(posedge sys_clk);
    check("forced", {8'h00, relay_on}, 16'h00fe);
    check("forced lit", {12'h000, yellow_led}, 16'h0001);
    for (int i = 0; i < 60; i++) begin
      wd = $urandom;
      if (i % 7 == 3) begin
        u_io_host.put_word(4'h5, wd[15:0]);
      end else begin
        u_io_host.put_word(4'h0, wd[15:0]);
        m_cmd = wd & 255;
      end
      @(posedge sys_clk);
      pins.manual  <= 4'($urandom);
      pins.pos1    <= 4'($urandom);
      pins.pos2    <= 4'($urandom);
      pins.alarm_n <= 8'($urandom);
      for (int k = 0; k < 8; k++) begin
        alarm_mode[k] <= relay_pkg::alarm_mode_t'($urandom_range(3));
      end
      if (i % 9 == 1) begin
        // enable low: outputs keep the state from before the new pins
        model(rel, rep);
        clk_en <= 1'b0;
        repeat (4) @(posedge sys_clk);
        check("frozen", {8'h00, relay_on}, 16'(rel & 255));
        check("frozen lit", {12'h000, yellow_led}, 16'(~rep & 15));
        clk_en <= 1'b1;
      end
      if (i % 5 == 2) begin
        pins.ext_rst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        pins.ext_rst <= 1'b0;
        m_cmd = 0;
      end else if (i % 5 == 4) begin
        pins.pwr_down <= 1'b1;
        repeat (4) @(posedge sys_clk);
        pins.pwr_down <= 1'b0;
        m_cmd = 0;
      end
      if (i == 30) begin
        srst <= 1'b1;
        @(posedge sys_clk);
        srst <= 1'b0;
        m_cmd = 0;
      end
      repeat (20) @(posedge sys_clk);
      model(rel, rep);
      check("relay", {8'h00, relay_on}, 16'(rel & 255));
      check("red", {8'h00, red_led}, 16'(rel & 255));
      check("yellow", {12'h000, yellow_led}, 16'(~rep & 15));
      u_io_host.get_word(4'h0, rdw);
      check("word", rdw, 16'((rep << 8) | m_cmd));
      if (i % 7 == 3) begin
        u_io_host.get_word(4'h5, rdw);
        check("unmapped", rdw, 16'h0000);
      end
    end
    test_done();
  end
endmodule : testbench
